// ---- rtl/modem_if_mem.sv ----
// host interface memory: registers, voice buffers, loop signalling, dsp ram access
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module modem_if_mem
  import modem_if_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_DIV,
  parameter int DETECT_RUN = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // datapath status
  input wire logic [3:0] tx_fifo_level,
  input wire logic [7:0] handshake_a_status,
  input wire logic [7:0] rate_seq_status,
  input wire logic v32_active,
  input wire logic self_echo_sync,
  // character format
  output logic [3:0] char_bits,
  output logic tx_ninth_used,
  output logic tx_ninth_bit,
  // voice
  input wire logic coder_valid,
  input wire logic [15:0] coder_word,
  output logic voice_tx_valid,
  output logic [15:0] voice_tx_word,
  // speaker
  output logic speaker_on,
  output logic [1:0] speaker_level,
  // loop signalling
  input wire logic tx_bit_tick,
  input wire logic rx_bit_tick,
  input wire logic rx_bit,
  output logic loop_tx_active,
  output logic loop_tx_bit,
  // dsp memory
  output dsp_req_t dsp_req,
  input wire logic [15:0] dsp_rdata
);
  typedef enum {LG_IDLE, LG_SCR, LG_ONES, LG_DONE} loop_state_t;
  typedef enum {MEM_IDLE, MEM_ISSUE, MEM_CAPTURE} mem_state_t;

  logic [7:0] vol_ctrl_r, vol_ctrl_nxt, det_en_r, det_en_nxt, proto_r, proto_nxt;
  logic [7:0] squelch_r, squelch_nxt, char_r, char_nxt, send_r, send_nxt;
  logic [7:0] vtx_up_r, vtx_up_nxt, vtx_lo_r, vtx_lo_nxt, pv_r, pv_nxt;
  logic [7:0] mode_cfg_r, mode_cfg_nxt, line_cfg_r, line_cfg_nxt;
  logic [7:0] dlo_r, dlo_nxt, dhi_r, dhi_nxt, mreq_r, mreq_nxt, alo_r, alo_nxt;
  logic [3:0] ahi_r, ahi_nxt;
  logic [15:0] vrx_r, vrx_nxt;
  logic rx_buffer_full_r, rx_buffer_full_nxt, vsync_r, vsync_nxt, first_r, first_nxt, drop_r, drop_nxt;
  logic tx_queue_half_full_r, seen_r, seen_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pslverr_r, pslverr_nxt;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [4:0] idx;
  logic acc, wr, rd;
  logic [15:0] div_r, div_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic tick_r;
  logic voice_cfg, fsk, mem_done;
  mem_state_t mst_r, mst_nxt;
  dsp_req_t dsp_req_r, dsp_req_nxt;
  logic [15:0] vtx_word_r, vtx_word_nxt;
  logic vtx_valid_r, vtx_valid_nxt;
  logic [3:0] char_bits_r;
  logic ninth_used_r, ninth_bit_r, spk_on_r;
  logic [1:0] spk_lvl_r;
  loop_state_t lst_r, lst_nxt;
  logic [6:0] scr_r, scr_nxt, dscr_r, dscr_nxt;
  logic [13:0] lcnt_r, lcnt_nxt;
  logic lbit_r, lbit_nxt, lact_r, lact_nxt;
  logic [6:0] zrun_r, zrun_nxt, orun_r, orun_nxt;
  logic scr_in, scr_out, desc;
  logic [13:0] scr_len;

  assign idx = paddr[6:2];
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign fsk = line_cfg_r[BIT_FSK];
  assign voice_cfg = (mode_cfg_r == CFG_VOICE_A) || (mode_cfg_r == CFG_VOICE_B) ||
                     (mode_cfg_r == CFG_VOICE_C) || (mode_cfg_r == CFG_VOICE_D);
  assign mem_done = (mst_r == MEM_CAPTURE);

  // read decode
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (paddr[7] || paddr[1:0] != 2'b00) rd_hit = 1'b0;
    else if (idx == IDX_VRX_UP) rd_byte = vrx_r[15:8];
    else if (idx == IDX_FIFO_VOL) rd_byte = {vol_ctrl_r[7:3], tx_queue_half_full_r, vol_ctrl_r[1:0]};
    else if (idx == IDX_LOOP_DET) rd_byte = det_en_r;
    else if (idx == IDX_PROTO) rd_byte = proto_r;
    else if (idx == IDX_SQUELCH) rd_byte = squelch_r;
    else if (idx == IDX_CHAR) rd_byte = char_r;
    else if (idx == IDX_LOOP_SEND) rd_byte = send_r;
    else if (idx == IDX_VSYNC) rd_byte = 8'(({7'h00, vsync_r} << BIT_VSYNC) |
                                            ({7'h00, rx_buffer_full_r} << BIT_RX_BUFFER_FULL));
    else if (idx == IDX_LINE_DROP) rd_byte = 8'({7'h00, drop_r} << BIT_DROP);
    else if (idx == IDX_HS_A) rd_byte = handshake_a_status;
    else if (idx == IDX_RATE_SEQ) rd_byte = rate_seq_status;
    else if (idx == IDX_LOOP_STAT) rd_byte = 8'({7'h00, seen_r} << BIT_SEEN);
    else if (idx == IDX_VTX_UP) rd_byte = vtx_up_r;
    else if (idx == IDX_PAR_VOICE) rd_byte = pv_r;
    else if (idx == IDX_MODE_CFG) rd_byte = mode_cfg_r;
    else if (idx == IDX_LINE_CFG) rd_byte = line_cfg_r;
    else if (idx == IDX_VRX_LO) rd_byte = vrx_r[7:0];
    else if (idx == IDX_VTX_LO) rd_byte = vtx_lo_r;
    else if (idx == IDX_MEM_DLO) rd_byte = dlo_r;
    else if (idx == IDX_MEM_DHI) rd_byte = dhi_r;
    else if (idx == IDX_MEM_REQ) rd_byte = mreq_r;
    else if (idx == IDX_MEM_ALO) rd_byte = alo_r;
    else if (idx == IDX_MEM_AHI) rd_byte = {4'h0, ahi_r};
    else rd_hit = 1'b0;
  end

  // bus answer and register writes
  always_comb
  begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (psel && !penable)
    begin
      prdata_nxt = {24'h000000, rd_byte};
      pslverr_nxt = !rd_hit;
    end
    vol_ctrl_nxt = vol_ctrl_r;
    det_en_nxt = det_en_r;
    proto_nxt = proto_r;
    squelch_nxt = squelch_r;
    char_nxt = char_r;
    send_nxt = send_r;
    vtx_up_nxt = vtx_up_r;
    vtx_lo_nxt = vtx_lo_r;
    pv_nxt = pv_r;
    mode_cfg_nxt = mode_cfg_r;
    line_cfg_nxt = line_cfg_r;
    dlo_nxt = dlo_r;
    dhi_nxt = dhi_r;
    mreq_nxt = mreq_r;
    alo_nxt = alo_r;
    ahi_nxt = ahi_r;
    if (wr && rd_hit)
    begin
      if (idx == IDX_FIFO_VOL) vol_ctrl_nxt = pwdata[7:0] & 8'hE0;
      else if (idx == IDX_LOOP_DET) det_en_nxt = pwdata[7:0];
      else if (idx == IDX_PROTO) proto_nxt = pwdata[7:0];
      else if (idx == IDX_SQUELCH) squelch_nxt = pwdata[7:0];
      else if (idx == IDX_CHAR) char_nxt = pwdata[7:0];
      else if (idx == IDX_LOOP_SEND) send_nxt = pwdata[7:0];
      else if (idx == IDX_VTX_UP) vtx_up_nxt = pwdata[7:0];
      else if (idx == IDX_VTX_LO) vtx_lo_nxt = pwdata[7:0];
      else if (idx == IDX_PAR_VOICE) pv_nxt = pwdata[7:0];
      else if (idx == IDX_MODE_CFG) mode_cfg_nxt = pwdata[7:0];
      else if (idx == IDX_LINE_CFG) line_cfg_nxt = pwdata[7:0];
      else if (idx == IDX_MEM_DLO) dlo_nxt = pwdata[7:0];
      else if (idx == IDX_MEM_DHI) dhi_nxt = pwdata[7:0];
      else if (idx == IDX_MEM_REQ) mreq_nxt = pwdata[7:0];
      else if (idx == IDX_MEM_ALO) alo_nxt = pwdata[7:0];
      else if (idx == IDX_MEM_AHI) ahi_nxt = pwdata[3:0];
    end
    if (mem_done && (!mreq_r[BIT_REQ_WR] || mem_method_t'(mreq_r[BIT_METHOD +: 2]) == M_DIAG))
    begin
      // eight-bit parameters land in low data only
      dlo_nxt = dsp_rdata[7:0];
      if (mem_method_t'(mreq_r[BIT_METHOD +: 2]) != M_8R8W) dhi_nxt = dsp_rdata[15:8];
    end
    if (mem_done)
    begin
      // request drops when done, a new write wins
      if (!(wr && idx == IDX_MEM_REQ)) mreq_nxt[BIT_REQ] = 1'b0;
    end
  end

  // voice receive and line status
  always_comb
  begin
    vrx_nxt = vrx_r;
    rx_buffer_full_nxt = rx_buffer_full_r;
    vsync_nxt = vsync_r;
    first_nxt = first_r;
    drop_nxt = drop_r;
    if (rd && idx == IDX_VRX_LO)
    begin
      rx_buffer_full_nxt = 1'b0;
      vsync_nxt = 1'b0;
    end
    if (!pv_r[BIT_RXV]) first_nxt = 1'b1;
    if (coder_valid && pv_r[BIT_RXV] && voice_cfg && !vol_ctrl_r[BIT_VHOLD])
    begin
      vrx_nxt = coder_word;
      rx_buffer_full_nxt = 1'b1;
      first_nxt = 1'b0;
      // first sample raises sync with full
      if (first_r) vsync_nxt = 1'b1;
    end
    if (rd && idx == IDX_LINE_DROP) drop_nxt = 1'b0;
    // self-sync in v32 flags a drop
    if (v32_active && self_echo_sync) drop_nxt = 1'b1;
  end

  // sample divider, voice transmit and dsp memory sequencer
  always_comb
  begin
    div_nxt = (div_r == 16'(SAMPLE_CYCLES - 1)) ? 16'h0000 : div_r + 16'h0001;
    vtx_word_nxt = vtx_word_r;
    vtx_valid_nxt = 1'b0;
    // voice transmit gated by enable and code
    if (tick_r && pv_r[BIT_TXV] && voice_cfg)
    begin
      vtx_word_nxt = {vtx_up_r, vtx_lo_r};
      vtx_valid_nxt = 1'b1;
    end
    mst_nxt = mst_r;
    dsp_req_nxt = '0;
    wait_nxt = 16'h0000;
    if (mst_r == MEM_IDLE && mreq_r[BIT_REQ])
      wait_nxt = (wait_r == 16'hFFFF) ? wait_r : wait_r + 16'h0001;
    case (mst_r)
      MEM_IDLE:
      begin
        // request looked at once per sample
        if (tick_r && mreq_r[BIT_REQ])
        begin
          mst_nxt = MEM_ISSUE;
          dsp_req_nxt.addr = {ahi_r, alo_r};
          dsp_req_nxt.re = 1'b1;
          dsp_req_nxt.wdata = {dlo_r, dlo_r};
          dsp_req_nxt.be = 2'b11;
          // one or two bytes moved per cycle
          case (mem_method_t'(mreq_r[BIT_METHOD +: 2]))
            M_8R8W: dsp_req_nxt.be = 2'b01;
            M_16R8W: dsp_req_nxt.be = mreq_r[BIT_BYTE_HI] ? 2'b10 : 2'b01;
            M_16R16W: dsp_req_nxt.wdata = {dhi_r, dlo_r};
            default: dsp_req_nxt.be = 2'b11;
          endcase
          if (mreq_r[BIT_REQ_WR] && mem_method_t'(mreq_r[BIT_METHOD +: 2]) != M_DIAG)
          begin
            dsp_req_nxt.we = 1'b1;
            dsp_req_nxt.re = 1'b0;
          end
        end
      end
      MEM_ISSUE: mst_nxt = MEM_CAPTURE;
      default: mst_nxt = MEM_IDLE;
    endcase
  end

  // loop signalling generator and detectors
  always_comb
  begin
    lst_nxt = lst_r;
    scr_nxt = scr_r;
    lcnt_nxt = lcnt_r;
    lbit_nxt = lbit_r;
    lact_nxt = lact_r;
    scr_in = !send_r[BIT_PREP];
    scr_len = send_r[BIT_PREP] ? PREP_BITS : (send_r[BIT_ACK] ? ACK_BITS : TERM_BITS);
    scr_out = scr_in ^ scr_r[SCR_TAP_A] ^ scr_r[SCR_TAP_B];
    case (lst_r)
      LG_IDLE:
        if (!fsk && (send_r[BIT_PREP] || send_r[BIT_ACK] || send_r[BIT_TERM]))
        begin
          lst_nxt = LG_SCR;
          lcnt_nxt = 14'h0000;
          scr_nxt = 7'h00;
        end
      LG_SCR:
        if (tx_bit_tick)
        begin
          // prep scrambles zeros; ack scrambles ones
          lbit_nxt = scr_out;
          lact_nxt = 1'b1;
          scr_nxt = {scr_r[5:0], scr_out};
          lcnt_nxt = lcnt_r + 14'h0001;
          if (lcnt_r == scr_len - 14'h0001)
          begin
            lcnt_nxt = 14'h0000;
            lst_nxt = (!send_r[BIT_PREP] && !send_r[BIT_ACK]) ? LG_ONES : LG_DONE;
          end
        end
      LG_ONES:
        if (tx_bit_tick)
        begin
          lbit_nxt = 1'b1;
          lcnt_nxt = lcnt_r + 14'h0001;
          if (lcnt_r == TERM_ONES - 14'h0001) lst_nxt = LG_DONE;
        end
      default:
        if (tx_bit_tick)
        begin
          lact_nxt = 1'b0;
          lbit_nxt = 1'b1;
        end
    endcase
    if (lst_r == LG_DONE && !lact_r && !(send_r[BIT_PREP] || send_r[BIT_ACK] ||
        send_r[BIT_TERM]))
      lst_nxt = LG_IDLE;
    if (fsk)
    begin
      lst_nxt = LG_IDLE;
      lact_nxt = 1'b0;
      lbit_nxt = 1'b1;
    end
    dscr_nxt = dscr_r;
    zrun_nxt = zrun_r;
    orun_nxt = orun_r;
    desc = rx_bit ^ dscr_r[SCR_TAP_A] ^ dscr_r[SCR_TAP_B];
    if (rx_bit_tick)
    begin
      dscr_nxt = {dscr_r[5:0], rx_bit};
      zrun_nxt = desc ? 7'h00 : ((zrun_r == 7'(DETECT_RUN)) ? zrun_r : zrun_r + 7'h01);
      orun_nxt = !desc ? 7'h00 : ((orun_r == 7'(DETECT_RUN)) ? orun_r : orun_r + 7'h01);
    end
    // outside fsk, any enabled detector flags the pattern
    seen_nxt = !fsk && ((det_en_r[0] && zrun_r == 7'(DETECT_RUN)) ||
               ((det_en_r[1] || det_en_r[2]) && orun_r == 7'(DETECT_RUN)));
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {vol_ctrl_r, det_en_r, squelch_r, char_r, send_r} <= {5{ZERO_RST}};
      {vtx_up_r, vtx_lo_r, pv_r, mode_cfg_r, line_cfg_r} <= {5{ZERO_RST}};
      {dlo_r, dhi_r, mreq_r, alo_r} <= {4{ZERO_RST}};
      proto_r <= PROTO_RST;
      ahi_r <= 4'h0;
      vrx_r <= 16'h0000;
      {rx_buffer_full_r, vsync_r, drop_r, tx_queue_half_full_r, seen_r, pready_r, pslverr_r} <= 7'h00;
      first_r <= 1'b1;
      prdata_r <= 32'h00000000;
      div_r <= 16'h0000;
      wait_r <= 16'h0000;
      tick_r <= 1'b0;
      mst_r <= MEM_IDLE;
      dsp_req_r <= '0;
      vtx_word_r <= 16'h0000;
      vtx_valid_r <= 1'b0;
      char_bits_r <= 4'h5;
      {ninth_used_r, ninth_bit_r, spk_on_r} <= 3'h0;
      spk_lvl_r <= 2'h0;
      lst_r <= LG_IDLE;
      {scr_r, dscr_r, zrun_r, orun_r} <= 28'h0000000;
      lcnt_r <= 14'h0000;
      lbit_r <= 1'b1;
      lact_r <= 1'b0;
    end
    else
    begin
      {vol_ctrl_r, det_en_r, proto_r, squelch_r} <= {vol_ctrl_nxt, det_en_nxt, proto_nxt,
                                                     squelch_nxt};
      {char_r, send_r, vtx_up_r, vtx_lo_r} <= {char_nxt, send_nxt, vtx_up_nxt, vtx_lo_nxt};
      {pv_r, mode_cfg_r, line_cfg_r} <= {pv_nxt, mode_cfg_nxt, line_cfg_nxt};
      {dlo_r, dhi_r, mreq_r, alo_r, ahi_r} <= {dlo_nxt, dhi_nxt, mreq_nxt, alo_nxt, ahi_nxt};
      {vrx_r, rx_buffer_full_r, vsync_r, first_r, drop_r} <= {vrx_nxt, rx_buffer_full_nxt, vsync_nxt,
                                                    first_nxt, drop_nxt};
      tx_queue_half_full_r <= (tx_fifo_level >= FIFO_HALF);
      seen_r <= seen_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pready_r <= psel && !penable;
      div_r <= div_nxt;
      wait_r <= wait_nxt;
      tick_r <= (div_r == 16'(SAMPLE_CYCLES - 1));
      mst_r <= mst_nxt;
      dsp_req_r <= dsp_req_nxt;
      vtx_word_r <= vtx_word_nxt;
      vtx_valid_r <= vtx_valid_nxt;
      char_bits_r <= 4'h5 + {2'b00, char_r[1:0]};
      ninth_used_r <= line_cfg_r[BIT_PAR_ON] && line_cfg_r[BIT_PAR_STUFF] &&
                      line_cfg_r[BIT_ASYNC] && char_r[1:0] == 2'b11;
      ninth_bit_r <= pv_r[BIT_STUFF];
      // zero is off, others are levels
      spk_on_r <= vol_ctrl_r[BIT_VOL +: 2] != 2'b00;
      spk_lvl_r <= vol_ctrl_r[BIT_VOL +: 2];
      {lst_r, scr_r, lcnt_r, lbit_r, lact_r} <= {lst_nxt, scr_nxt, lcnt_nxt, lbit_nxt,
                                                 lact_nxt};
      {dscr_r, zrun_r, orun_r} <= {dscr_nxt, zrun_nxt, orun_nxt};
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign char_bits = char_bits_r;
  assign tx_ninth_used = ninth_used_r;
  assign tx_ninth_bit = ninth_bit_r;
  assign voice_tx_valid = vtx_valid_r;
  assign voice_tx_word = vtx_word_r;
  assign speaker_on = spk_on_r;
  assign speaker_level = spk_lvl_r;
  assign loop_tx_active = lact_r;
  assign loop_tx_bit = lbit_r;
  assign dsp_req = dsp_req_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_tx_queue_half_full_level: assert property ((tx_fifo_level >= 4'h4) |=> tx_queue_half_full_r)
    else $error("half-full flag missed");
  a_ninth_bit_pass: assert property (ninth_used_r |-> tx_ninth_bit == $past(pv_r[0]))
    else $error("ninth bit wrong");
  a_voice_tx_gate: assert property (voice_tx_valid |-> $past(pv_r[4] && voice_cfg))
    else $error("voice sent while disabled");
  a_voice_hold_block: assert property (
    (coder_valid && vol_ctrl_r[5]) |=> vrx_r == $past(vrx_r))
    else $error("held sample reached buffer");
  a_vsync_with_full: assert property (vsync_r |-> rx_buffer_full_r)
    else $error("sync without full");
  a_speaker_off: assert property ((vol_ctrl_r[7:6] == 2'b00) |=> !speaker_on)
    else $error("speaker on at level zero");
  a_mem_one_tick: assert property (
    (mst_r == MEM_IDLE && mreq_r[0]) |-> wait_r < 16'(SAMPLE_CYCLES))
    else $error("request not serviced");
  a_req_clears: assert property ((mst_r == MEM_ISSUE) |-> ##2 (!mreq_r[0] || $past(wr, 1)))
    else $error("request bit left set");
  a_diag_no_write: assert property (
    (mst_r == MEM_ISSUE && mreq_r[3:2] == 2'b11) |-> !dsp_req.we)
    else $error("diagnostic wrote memory");
  a_loop_fsk_quiet: assert property (fsk |=> !loop_tx_active)
    else $error("loop pattern in fsk");
  c_voice_sent: cover property (voice_tx_valid);
  c_mem_write: cover property (dsp_req.we);
  c_loop_done: cover property (lst_r == LG_DONE);
endmodule : modem_if_mem

// ---- rtl/modem_if_pkg.sv ----
// shared constants and carrier types for the modem host interface memory
package modem_if_pkg;
  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_VRX_UP = 5'h00;
  localparam logic [4:0] IDX_FIFO_VOL = 5'h01;
  localparam logic [4:0] IDX_LOOP_DET = 5'h02;
  localparam logic [4:0] IDX_PROTO = 5'h04;
  localparam logic [4:0] IDX_SQUELCH = 5'h05;
  localparam logic [4:0] IDX_CHAR = 5'h06;
  localparam logic [4:0] IDX_LOOP_SEND = 5'h08;
  localparam logic [4:0] IDX_VSYNC = 5'h0A;
  localparam logic [4:0] IDX_LINE_DROP = 5'h0B;
  localparam logic [4:0] IDX_HS_A = 5'h0D;
  localparam logic [4:0] IDX_RATE_SEQ = 5'h0E;
  localparam logic [4:0] IDX_LOOP_STAT = 5'h0F;
  localparam logic [4:0] IDX_VTX_UP = 5'h10;
  localparam logic [4:0] IDX_PAR_VOICE = 5'h11;
  localparam logic [4:0] IDX_MODE_CFG = 5'h12;
  localparam logic [4:0] IDX_LINE_CFG = 5'h14;
  localparam logic [4:0] IDX_VRX_LO = 5'h16;
  localparam logic [4:0] IDX_VTX_LO = 5'h17;
  localparam logic [4:0] IDX_MEM_DLO = 5'h18;
  localparam logic [4:0] IDX_MEM_DHI = 5'h19;
  localparam logic [4:0] IDX_MEM_REQ = 5'h1B;
  localparam logic [4:0] IDX_MEM_ALO = 5'h1C;
  localparam logic [4:0] IDX_MEM_AHI = 5'h1D;
  // field positions
  localparam int BIT_TX_QUEUE_HALF_FULL = 2;
  localparam int BIT_VHOLD = 5;
  localparam int BIT_VOL = 6;
  localparam int BIT_STUFF = 0;
  localparam int BIT_RXV = 3;
  localparam int BIT_TXV = 4;
  localparam int BIT_PREP = 2;
  localparam int BIT_ACK = 3;
  localparam int BIT_TERM = 4;
  localparam int BIT_VSYNC = 2;
  localparam int BIT_RX_BUFFER_FULL = 3;
  localparam int BIT_DROP = 1;
  localparam int BIT_SEEN = 0;
  localparam int BIT_PAR_ON = 0;
  localparam int BIT_PAR_STUFF = 1;
  localparam int BIT_FSK = 2;
  localparam int BIT_ASYNC = 3;
  localparam int BIT_REQ = 0;
  localparam int BIT_REQ_WR = 1;
  localparam int BIT_METHOD = 2;
  localparam int BIT_BYTE_HI = 4;
  // reset values
  localparam logic [7:0] PROTO_RST = 8'h20;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // voice configuration codes
  localparam logic [7:0] CFG_VOICE_A = 8'h80;
  localparam logic [7:0] CFG_VOICE_B = 8'h81;
  localparam logic [7:0] CFG_VOICE_C = 8'h83;
  localparam logic [7:0] CFG_VOICE_D = 8'h86;
  // counts and timing
  localparam logic [3:0] FIFO_HALF = 4'h4;
  localparam logic [13:0] PREP_BITS = 14'd2048;
  localparam logic [13:0] ACK_BITS = 14'd1948;
  localparam logic [13:0] TERM_BITS = 14'd8192;
  localparam logic [13:0] TERM_ONES = 14'd64;
  localparam int SCR_TAP_A = 3;
  localparam int SCR_TAP_B = 6;
  localparam int CLK_HZ = 200000000;
  localparam int SAMPLE_HZ = 7200;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  // dsp memory access methods
  typedef enum logic [1:0] {M_8R8W, M_16R8W, M_16R16W, M_DIAG} mem_method_t;
  // request towards dsp memory
  typedef struct packed {
    logic re;
    logic we;
    logic [1:0] be;
    logic [11:0] addr;
    logic [15:0] wdata;
  } dsp_req_t;
endpackage : modem_if_pkg

// ---- verif/dsp_ram_model.sv ----
// dsp ram model answering the block's memory requests
`timescale 1ns/10ps
module dsp_ram_model
  import modem_if_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // request and answer
  input wire dsp_req_t dsp_req,
  output logic [15:0] dsp_rdata
);
  logic [15:0] mem [0:4095];
  logic [11:0] addr_q;
  logic re_q;
  logic tgl;
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = {4'h5, i[11:0]};
    re_q = 1'b0;
    tgl = 1'b0;
    addr_q = 12'h000;
  end
  always @(posedge ref_clk)
  begin
    tgl <= ~tgl;
    re_q <= dsp_req.re;
    if (dsp_req.re)
      addr_q <= dsp_req.addr;
    if (dsp_req.we && dsp_req.be[0])
      mem[dsp_req.addr][7:0] <= dsp_req.wdata[7:0];
    if (dsp_req.we && dsp_req.be[1])
      mem[dsp_req.addr][15:8] <= dsp_req.wdata[15:8];
  end
  // data valid two cycles only, then a changing pattern
  assign dsp_rdata = dsp_req.re ? mem[dsp_req.addr] : re_q ? mem[addr_q] : {8{tgl, ~tgl}};
endmodule : dsp_ram_model

// ---- verif/modem_host_interface_memory_tb_top.sv ----
// testbench for the modem host interface memory
`timescale 1ns/10ps
module modem_host_interface_memory_tb_top;
  import modem_if_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, v32_active, self_echo_sync;
  logic tx_ninth_used, tx_ninth_bit, coder_valid, voice_tx_valid, speaker_on, er;
  logic rx_bit_tick, rx_bit, loop_tx_active, loop_tx_bit, lb;
  logic [6:0] sv;
  logic [7:0] paddr, rd;
  logic [31:0] pwdata, prdata;
  logic [3:0] tx_fifo_level, char_bits;
  logic [15:0] coder_word, voice_tx_word, dsp_rdata;
  logic [1:0] speaker_level;
  dsp_req_t dsp_req;
  int err_total, total_checks, n, cnt, bad;
  int bits [3] = '{2048, 1948, 8256};
  modem_if_mem #(.SAMPLE_CYCLES(20), .DETECT_RUN(8)) DUT (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fifo_level,
    .handshake_a_status(8'h3C), .rate_seq_status(8'hC3), .v32_active, .self_echo_sync,
    .char_bits, .tx_ninth_used, .tx_ninth_bit, .coder_valid, .coder_word, .voice_tx_valid,
    .voice_tx_word, .speaker_on, .speaker_level, .tx_bit_tick(1'b1), .rx_bit_tick, .rx_bit,
    .loop_tx_active, .loop_tx_bit, .dsp_req, .dsp_rdata);
  dsp_ram_model ram (.ref_clk, .dsp_req, .dsp_rdata);
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [4:0] idx, input logic [7:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      chk("apb answer", 0, 1);
      tally_and_finish();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic coder(input logic [15:0] w);
    @(posedge ref_clk);
    coder_word <= w;
    coder_valid <= 1'b1;
    @(posedge ref_clk);
    coder_valid <= 1'b0;
  endtask : coder
  task automatic mem(input logic [7:0] req);
    apb(1'b1, IDX_MEM_REQ, req);
    n = 0;
    do
    begin
      apb(1'b0, IDX_MEM_REQ, 8'h00);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0)
    begin
      chk("mem done", 0, 1);
      tally_and_finish();
    end
  endtask : mem
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, tx_fifo_level} = {3'b100, 45'h0};
    {v32_active, self_echo_sync, coder_valid, coder_word, rx_bit_tick, rx_bit} = 21'h0;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, IDX_PROTO, 8'h00);
    chk("proto reset", rd, PROTO_RST);
    apb(1'b1, 5'h03, 8'hFF);
    chk("unmapped", {er, rd}, 9'h100);
    apb(1'b0, IDX_HS_A, 8'h00);
    chk("status a", rd, 8'h3C);
    apb(1'b0, IDX_RATE_SEQ, 8'h00);
    chk("rate seq", rd, 8'hC3);
    for (int i = 3; i < 5; i++)
    begin
      tx_fifo_level <= 4'(i);
      apb(1'b0, IDX_FIFO_VOL, 8'h00);
      chk("half full", rd[BIT_TX_QUEUE_HALF_FULL], i >= 4);
    end
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, IDX_FIFO_VOL, 8'(v << 6));
      repeat (2) @(posedge ref_clk);
      chk("volume", {speaker_on, speaker_level}, {v != 0, 2'(v)});
    end
    apb(1'b1, IDX_LINE_CFG, 8'h0B);
    apb(1'b1, IDX_PAR_VOICE, 8'h01);
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, IDX_CHAR, 8'(v));
      repeat (2) @(posedge ref_clk);
      chk("char bits", char_bits, 5 + v);
    end
    chk("ninth bit", {tx_ninth_used, tx_ninth_bit}, 2'b11);
    apb(1'b1, IDX_VTX_UP, 8'h12);
    apb(1'b1, IDX_VTX_LO, 8'h34);
    apb(1'b1, IDX_PAR_VOICE, 8'h18);
    for (int c = 0; c < 2; c++)
    begin
      apb(1'b1, IDX_MODE_CFG, c ? CFG_VOICE_D : 8'h00);
      cnt = 0;
      repeat (50)
      begin
        @(posedge ref_clk);
        cnt += (voice_tx_valid === 1'b1);
        if (voice_tx_valid === 1'b1)
          chk("voice tx word", voice_tx_word, 16'h1234);
      end
      chk("voice tx gate", cnt != 0, c);
    end
    coder(16'hA55A);
    apb(1'b0, IDX_VSYNC, 8'h00);
    chk("voice sync", rd & 8'h0C, 8'h0C);
    apb(1'b0, IDX_VRX_UP, 8'h00);
    chk("rx upper", rd, 8'hA5);
    apb(1'b0, IDX_VRX_LO, 8'h00);
    chk("rx lower", rd, 8'h5A);
    apb(1'b1, IDX_FIFO_VOL, 8'h20);
    coder(16'h1234);
    apb(1'b0, IDX_VRX_UP, 8'h00);
    chk("voice hold", rd, 8'hA5);
    apb(1'b1, IDX_MEM_AHI, 8'h0A);
    apb(1'b1, IDX_MEM_ALO, 8'hBC);
    apb(1'b1, IDX_MEM_DLO, 8'h77);
    apb(1'b1, IDX_MEM_DHI, 8'h66);
    mem(8'h0B);
    apb(1'b1, IDX_MEM_DLO, 8'h00);
    mem(8'h09);
    apb(1'b0, IDX_MEM_DLO, 8'h00);
    chk("mem word lo", rd, 8'h77);
    apb(1'b1, IDX_MEM_ALO, 8'hBD);
    mem(8'h01);
    apb(1'b0, IDX_MEM_DLO, 8'h00);
    chk("mem byte", rd, 8'hBD);
    apb(1'b0, IDX_MEM_DHI, 8'h00);
    chk("mem hi kept", rd, 8'h66);
    apb(1'b1, IDX_MEM_DLO, 8'hC4);
    mem(8'h17);
    mem(8'h0F);
    apb(1'b0, IDX_MEM_DHI, 8'h00);
    chk("byte write hi", rd, 8'hC4);
    apb(1'b0, IDX_MEM_DLO, 8'h00);
    chk("diag no write", rd, 8'hBD);
    v32_active <= 1'b1;
    self_echo_sync <= 1'b1;
    apb(1'b0, IDX_LINE_DROP, 8'h00);
    apb(1'b0, IDX_LINE_DROP, 8'h00);
    chk("line drop", rd[BIT_DROP], 1'b1);
    apb(1'b1, IDX_LOOP_DET, 8'h01);
    rx_bit_tick <= 1'b1;
    repeat (16) @(posedge ref_clk);
    apb(1'b0, IDX_LOOP_STAT, 8'h00);
    chk("pattern seen", rd[BIT_SEEN], 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, IDX_LOOP_SEND, 8'(4 << i));
      cnt = 0;
      bad = 0;
      sv = 7'h00;
      repeat (8300)
      begin
        @(posedge ref_clk);
        if (loop_tx_active === 1'b1)
        begin
          cnt++;
          lb = (i == 2 && cnt > 8192) ? 1'b1 : (i != 0) ^ sv[3] ^ sv[6];
          bad += (loop_tx_bit !== lb);
          sv = {sv[5:0], lb};
        end
      end
      chk("loop bits", cnt, bits[i]);
      chk("loop stream", bad, 0);
      apb(1'b1, IDX_LOOP_SEND, 8'h00);
    end
    tally_and_finish();
  end
endmodule : modem_host_interface_memory_tb_top
